//--- hw/fsr_top.sv
/*
   Fixed-station control: reset sequencing, command selection by own address,
   repeat-request attempt control, mobile address screening and indicators.
   Assumes decoded host commands and synchronous inputs on mclk.
*/
`include "fsr_regs.svh"
module fsr_top
   import fsr_pkg::*;
#(
   parameter int INIT_CYC = `FSR_INIT_CYC,
   parameter int EXT_CYC  = `FSR_EXT_CYC
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // host command port
   input  wire fsr_cmd_s          cmd,
   output fsr_resp_s              resp_r,
   // switches and contact
   input  wire logic [7:0]        address_rotary_switch,
   input  wire logic [7:0]        chan_switch,
   input  wire logic              ext_reset_closed,
   // air link
   input  wire logic              air_ack,
   input  wire logic              air_miss,
   input  wire logic              mob_valid,
   input  wire logic [11:0]       mob_src,
   input  wire logic [11:0]       mob_dst,
   input  wire logic              feeder_tx_busy,
   input  wire logic              rssi_valid,
   input  wire logic signed [7:0] rssi_dbm,
   // status outputs
   output logic                   prog_restart_r,
   output logic                   init_busy_r,
   output logic [11:0]            own_addr_r,
   output logic [7:0]             chan_r,
   output logic                   tx_attempt_r,
   output logic                   tx_bch_r,
   output logic                   mob_accept_r,
   output logic                   mob_reject_r,
   output logic                   downlink_led_r,
   output logic [7:0]             bar_led_r
);
   typedef enum logic [1:0] {ST_INIT, ST_ACK, ST_RUN} fsr_st_e;
   localparam int CW = $clog2(INIT_CYC + 1);
   localparam int EW = $clog2(EXT_CYC + 1);

   fsr_st_e   st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [EW-1:0] ext_r, ext_nxt;
   logic      ext_d_r, ack_pend_r, ack_pend_nxt, rd_pend_r, rd_pend_nxt;
   logic      arq_busy_r, arq_busy_nxt, arq_pend_r, arq_pend_nxt, arq_ok_r, arq_ok_nxt;
   logic [2:0] try_r, try_nxt;
   fsr_resp_s resp_nxt;
   logic      restart_nxt, att_nxt, bch_nxt, macc_nxt, mrej_nxt;
   logic      take, ext_fire, cfg_wr, cfg_rd;
   logic [7:0] cfg_q, bar_nxt;
   logic [5:0] over;

   // a long closure counts only at release, so the contact can be held freely
   assign ext_fire = ext_d_r && !ext_reset_closed && ext_r == EW'(EXT_CYC);
   // commands are taken only when running and addressed to this station
   assign take = cmd.valid && st_r == ST_RUN && cmd.addr == own_addr_r;
   assign cfg_wr = take && cmd.code == CMD_FRQ_WR &&
                   cmd.arg >= `FSR_CHAN_MIN && cmd.arg <= `FSR_CHAN_MAX;
   assign cfg_rd = take && cmd.code == CMD_FRQ_RD;

   fsr_cfg_mem #(.W(8), .DEPTH(4)) u_cfg (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .restore      (prog_restart_r),
      .chan_default (chan_switch),
      .wr_en        (cfg_wr),
      .rd_en        (cfg_rd),
      .addr         (`FSR_CFG_CHAN),
      .wdata        (cmd.arg),
      .rdata_r      (cfg_q)
   );

   // one comparator per 5 dB step above the floor
   for (genvar g = 0; g < 6; g++) begin : g_bar
      assign over[g] = int'(rssi_dbm) > `FSR_BAR_FLOOR + g * `FSR_BAR_STEP;
   end

   // sequencer, responses and repeat-request control
   always_comb begin
      st_nxt       = st_r;
      cnt_nxt      = cnt_r;
      ack_pend_nxt = ack_pend_r;
      rd_pend_nxt  = cfg_rd;
      restart_nxt  = 1'b0;
      resp_nxt     = '0;
      arq_busy_nxt = arq_busy_r;
      arq_pend_nxt = arq_pend_r;
      arq_ok_nxt   = arq_ok_r;
      try_nxt      = try_r;
      att_nxt      = 1'b0;
      bch_nxt      = tx_bch_r;
      ext_nxt      = (ext_reset_closed && ext_r != EW'(EXT_CYC)) ? ext_r + 1'b1 :
                     (ext_reset_closed ? ext_r : '0);
      case (st_r)
         ST_INIT: begin
            if (cnt_r == CW'(INIT_CYC - 1)) begin
               st_nxt = ST_ACK;
               if (ack_pend_r)
                  resp_nxt = '{valid: 1'b1, code: RSP_OK, data: 8'h00};
               ack_pend_nxt = 1'b0;
            end else
               cnt_nxt = cnt_r + 1'b1;
         end
         ST_ACK: st_nxt = ST_RUN;
         ST_RUN: begin
            if (rd_pend_r)
               resp_nxt = '{valid: 1'b1, code: RSP_CHAN, data: cfg_q};
            else if (take && cmd.code == CMD_FRQ_WR)
               resp_nxt = '{valid: 1'b1, code: cfg_wr ? RSP_OK : RSP_NG, data: 8'h00};
            else if (take && cmd.code == CMD_TX && arq_busy_r)
               resp_nxt = '{valid: 1'b1, code: RSP_NG, data: 8'h00};
            else if (arq_pend_r && !take) begin
               resp_nxt = '{valid: 1'b1, code: arq_ok_r ? RSP_OK : RSP_NG, data: 8'h00};
               arq_pend_nxt = 1'b0;
            end
            // plain attempts first, block-coded ones from the fourth on
            if (arq_busy_r && air_ack) begin
               arq_busy_nxt = 1'b0;
               arq_pend_nxt = 1'b1;
               arq_ok_nxt   = 1'b1;
            end else if (arq_busy_r && air_miss) begin
               if (try_r == `FSR_ARQ_LAST) begin
                  arq_busy_nxt = 1'b0;
                  arq_pend_nxt = 1'b1;
                  arq_ok_nxt   = 1'b0;
               end else begin
                  try_nxt = try_r + 3'h1;
                  att_nxt = 1'b1;
                  bch_nxt = (try_r + 3'h1) >= `FSR_ARQ_BCH;
               end
            end else if (take && cmd.code == CMD_TX && !arq_busy_r && !arq_pend_r) begin
               arq_busy_nxt = 1'b1;
               try_nxt      = 3'h0;
               att_nxt      = 1'b1;
               bch_nxt      = 1'b0;
            end
            if (take && cmd.code == CMD_RST) begin
               st_nxt       = ST_INIT;
               cnt_nxt      = '0;
               restart_nxt  = 1'b1;
               ack_pend_nxt = 1'b1;
               rd_pend_nxt  = 1'b0;
            end
         end
         default: st_nxt = ST_INIT;
      endcase
      // the contact wins over the sequencer and drops a pending OK, but an answer decided in the same cycle still goes out
      if (ext_fire) begin
         st_nxt       = ST_INIT;
         cnt_nxt      = '0;
         restart_nxt  = 1'b1;
         ack_pend_nxt = 1'b0;
         rd_pend_nxt  = 1'b0;
      end
      if (st_nxt == ST_INIT) begin
         arq_busy_nxt = 1'b0;
         arq_pend_nxt = 1'b0;
         att_nxt      = 1'b0;
         bch_nxt      = 1'b0;
      end
      // mobile frames: fixed destination, source inside the mobile range
      macc_nxt = mob_valid && st_r == ST_RUN && mob_dst == `FSR_FIXED_DEST &&
                 mob_src >= `FSR_MOB_LO && mob_src <= `FSR_MOB_HI;
      mrej_nxt = mob_valid && st_r == ST_RUN && !macc_nxt;
      bar_nxt  = rssi_valid ? (`FSR_BAR_BASE | {over, 2'b00}) : bar_led_r;
   end

   // state registers; power-up runs the same initialisation without an OK
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_r           <= ST_INIT;
         cnt_r          <= '0;
         ext_r          <= '0;
         ext_d_r        <= 1'b0;
         ack_pend_r     <= 1'b0;
         rd_pend_r      <= 1'b0;
         arq_busy_r     <= 1'b0;
         arq_pend_r     <= 1'b0;
         arq_ok_r       <= 1'b0;
         try_r          <= 3'h0;
         resp_r         <= '0;
         prog_restart_r <= 1'b1;
         init_busy_r    <= 1'b1;
         own_addr_r     <= `FSR_ADDR_RST;
         chan_r         <= `FSR_CFG_RST;
         tx_attempt_r   <= 1'b0;
         tx_bch_r       <= 1'b0;
         mob_accept_r   <= 1'b0;
         mob_reject_r   <= 1'b0;
         downlink_led_r <= 1'b0;
         bar_led_r      <= `FSR_BAR_BASE;
      end else begin
         st_r           <= st_nxt;
         cnt_r          <= cnt_nxt;
         ext_r          <= ext_nxt;
         ext_d_r        <= ext_reset_closed;
         ack_pend_r     <= ack_pend_nxt;
         rd_pend_r      <= rd_pend_nxt;
         arq_busy_r     <= arq_busy_nxt;
         arq_pend_r     <= arq_pend_nxt;
         arq_ok_r       <= arq_ok_nxt;
         try_r          <= try_nxt;
         resp_r         <= resp_nxt;
         prog_restart_r <= restart_nxt;
         init_busy_r    <= st_nxt != ST_RUN;
         own_addr_r     <= {`FSR_ADDR_TOP, address_rotary_switch};
         chan_r         <= cfg_q;
         tx_attempt_r   <= att_nxt;
         tx_bch_r       <= bch_nxt;
         mob_accept_r   <= macc_nxt;
         mob_reject_r   <= mrej_nxt;
         downlink_led_r <= feeder_tx_busy;
         bar_led_r      <= bar_nxt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_rst_taken;
      take && cmd.code == CMD_RST;
   endsequence
   sequence s_restart;
      prog_restart_r ##1 (st_r == ST_INIT);
   endsequence

   property p_restart;
      s_rst_taken |=> s_restart;
   endproperty
   a_restart: assert property (p_restart) else $error("reset command did not restart");
   property p_restore;
      s_rst_taken ##2 1'b1 |-> u_cfg.mem_r[0] == $past(chan_switch);
   endproperty
   a_restore: assert property (p_restore) else $error("channel not restored");
   property p_init_len;
      (st_r == ST_INIT) && (st_nxt == ST_ACK) |-> cnt_r == CW'(INIT_CYC - 1);
   endproperty
   a_init_len: assert property (p_init_len) else $error("initialisation length wrong");
   property p_ok_late;
      (resp_r.valid && resp_r.code == RSP_OK && $past(st_r == ST_INIT)) |-> st_r == ST_ACK;
   endproperty
   a_ok_late: assert property (p_ok_late) else $error("OK outside end of init");
   property p_addr;
      reset_n |=> own_addr_r == {4'h1, $past(address_rotary_switch)};
   endproperty
   a_addr: assert property (p_addr) else $error("own address wrong");
   property p_select;
      cmd.valid && cmd.addr != own_addr_r && st_r == ST_RUN && !ext_fire |=> !prog_restart_r;
   endproperty
   a_select: assert property (p_select) else $error("foreign command accepted");
   property p_bar;
      bar_led_r[1:0] == 2'b11 && ((bar_led_r & (bar_led_r + 8'h01)) == 8'h00);
   endproperty
   a_bar: assert property (p_bar) else $error("bar not a thermometer from two");
   property p_ext;
      ext_fire |=> prog_restart_r ##1 (st_r == ST_INIT)[*2];
   endproperty
   a_ext: assert property (p_ext) else $error("contact release missed");
   property p_mob;
      mob_accept_r |-> $past(mob_src) >= 12'h400 && $past(mob_src) <= 12'h9FF;
   endproperty
   a_mob: assert property (p_mob) else $error("mobile address out of range");
   property p_bch;
      tx_attempt_r |-> tx_bch_r == (try_r >= 3'h3);
   endproperty
   a_bch: assert property (p_bch) else $error("coding mode wrong for attempt");
   property p_ignore;
      reset_n && st_r != ST_RUN && !ext_fire |=> !prog_restart_r && !$past(cfg_wr);
   endproperty
   a_ignore: assert property (p_ignore) else $error("command taken during init");
   property p_led;
      reset_n |=> downlink_led_r == $past(feeder_tx_busy);
   endproperty
   a_led: assert property (p_led) else $error("downlink indicator dark");
endmodule : fsr_top

//--- hw/fsr_regs.svh
/*
   Constants of the fixed-station reset, address and status block.
   Assumes a 10 MHz mclk and that it is included by bare name.
*/
// Contract
// - Reset command restarts program from start
// - Reset restores configuration to power-on values
// - Reset re-initialises hardware, about 300 ms
// - OK sent only after initialisation ends
// - Own address 100h to 1FFh, top digit 1
// - Lower two digits from address rotary switch
// - Own address selects station for host commands
// - Downlink indicator lit while packets go out
// - Eight-segment bar, 5 dB steps from -90dBm
// - Contact closed over 10 ms is hardware reset
// - Accept mobile addresses 400h to 9FFh only
// - Air link uses repeat request plus block code
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH
`define FSR_CLK_HZ      10000000
`define FSR_INIT_MS     300
`define FSR_INIT_CYC    ((`FSR_CLK_HZ / 1000) * `FSR_INIT_MS)
`define FSR_EXT_MS      10
`define FSR_EXT_CYC     ((`FSR_CLK_HZ / 1000) * `FSR_EXT_MS + 1)
`define FSR_ADDR_TOP    4'h1
`define FSR_ADDR_RST    12'h100
`define FSR_FIXED_DEST  12'h001
`define FSR_MOB_LO      12'h400
`define FSR_MOB_HI      12'h9FF
`define FSR_ARQ_BCH     3'h3
`define FSR_ARQ_LAST    3'h5
`define FSR_BAR_FLOOR   (-90)
`define FSR_BAR_STEP    5
`define FSR_BAR_BASE    8'h03
`define FSR_CFG_CHAN    2'h0
`define FSR_CFG_RST     8'h00
`define FSR_CHAN_MIN    8'h01
`define FSR_CHAN_MAX    8'h32
`endif

//--- hw/fsr_pkg.sv
/*
   Types shared by the fixed-station control block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package fsr_pkg;
   typedef enum logic [1:0] {CMD_RST, CMD_FRQ_WR, CMD_FRQ_RD, CMD_TX} fsr_cmd_e;
   typedef enum logic [1:0] {RSP_OK, RSP_NG, RSP_CHAN} fsr_resp_e;
   typedef struct packed {
      logic        valid;
      fsr_cmd_e    code;
      logic [11:0] addr;
      logic [7:0]  arg;
   } fsr_cmd_s;
   typedef struct packed {
      logic        valid;
      fsr_resp_e   code;
      logic [7:0]  data;
   } fsr_resp_s;
endpackage : fsr_pkg

//--- hw/fsr_cfg_mem.sv
/*
   Configuration storage words with a one-cycle restore and registered read.
   Assumes the owner keeps writes and restore apart in time.
*/
`include "fsr_regs.svh"
module fsr_cfg_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     reset_n,
   // restore to power-on contents
   input  wire logic                     restore,
   input  wire logic [W-1:0]             chan_default,
   // access port
   input  wire logic                     wr_en,
   input  wire logic                     rd_en,
   input  wire logic [$clog2(DEPTH)-1:0] addr,
   input  wire logic [W-1:0]             wdata,
   output logic      [W-1:0]             rdata_r
);
   logic [W-1:0] mem_r   [DEPTH];
   logic [W-1:0] mem_nxt [DEPTH];
   logic [W-1:0] rdata_nxt;

   // restore beats a write: settings made before the reset are discarded
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         if (restore)
            mem_nxt[i] = (i == int'(`FSR_CFG_CHAN)) ? chan_default : W'(`FSR_CFG_RST);
         else if (wr_en && addr == i[$clog2(DEPTH)-1:0])
            mem_nxt[i] = wdata;
         else
            mem_nxt[i] = mem_r[i];
      end
      rdata_nxt = rd_en ? mem_r[addr] : rdata_r;
   end

   // storage
   always_ff @(posedge mclk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (!reset_n)
            mem_r[i] <= W'(`FSR_CFG_RST);
         else
            mem_r[i] <= mem_nxt[i];
      end
      if (!reset_n)
         rdata_r <= W'(`FSR_CFG_RST);
      else
         rdata_r <= rdata_nxt;
   end
endmodule : fsr_cfg_mem

//--- dv/fsr_host_model.sv
/*
   Host computer model: sends decoded commands and latches every answer.
   Assumes it shares mclk with the block and is driven by bench tasks.
*/
module fsr_host_model
   import fsr_pkg::*;
(
   // clock and reset
   input  wire logic      mclk,
   input  wire logic      reset_n,
   // status and answers from the block
   input  wire logic      init_busy_r,
   input  wire fsr_resp_s resp_r,
   // command toward the block
   output fsr_cmd_s       cmd
);
   timeunit 1ns;
   timeprecision 1ns;
   fsr_resp_s rsp_last;
   int        rsp_cnt = 0;

   initial cmd = '0;

   // answers stand one cycle only, so latch them at the edge they are seen
   always @(posedge mclk) begin
      if (!reset_n) rsp_cnt <= 0;
      else if (resp_r.valid) begin
         rsp_last <= resp_r;
         rsp_cnt  <= rsp_cnt + 1;
      end
   end

   // a polite host holds off until init ends; polite=0 breaks that on purpose
   task automatic send(input fsr_cmd_e c, input logic [11:0] a, input logic [7:0] g,
                       input bit polite);
      @(posedge mclk);
      while (polite && init_busy_r) @(posedge mclk);
      cmd <= '{1'b1, c, a, g};
      @(posedge mclk);
      cmd <= '0;
   endtask : send
endmodule : fsr_host_model

//--- dv/fsr_top_tb.sv
/*
   Self-checking bench of the fixed-station control block.
   Assumes the short init and contact counts set below and the host model.
*/
module fsr_top_tb;
   import fsr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int INIT = 20; // shortened init so the run stays brief
   localparam int EXT  = 8;
   logic              mclk = 1'b0, reset_n = 1'b0, ext_c = 1'b0, feed = 1'b0;
   logic              air_ack = 1'b0, air_miss = 1'b0, mob_v = 1'b0, rssi_v = 1'b0;
   logic [11:0]       mob_s = 12'h000, mob_d = 12'h000, own;
   logic signed [7:0] rssi = 8'h00;
   logic [31:0]       rnd = 32'h0001_3410;
   logic [7:0]        rot = 8'h5A, chsw = 8'h07, cur, ch;
   logic              prog_restart_r, init_busy_r, tx_attempt_r, tx_bch_r, seen, ok;
   logic              mob_accept_r, mob_reject_r, downlink_led_r;
   logic [11:0]       own_addr_r;
   logic [7:0]        chan_r, bar_led_r;
   fsr_cmd_s          cmd;
   fsr_resp_s         resp_r;
   int                miscompares = 0, checked = 0, cyc = 0, dt, n0, t0, miss;
   logic signed [7:0] bars [8] = '{-91, -90, -89, -86, -85, -66, -65, -64};
   logic [11:0]       srcs [6] = '{12'h3FF, 12'h400, 12'h9FF, 12'hA00, 12'h001, 12'hFFF};

   fsr_top #(.INIT_CYC(INIT), .EXT_CYC(EXT)) dut (.mclk(mclk), .reset_n(reset_n),
      .cmd(cmd), .resp_r(resp_r), .address_rotary_switch(rot), .chan_switch(chsw),
      .ext_reset_closed(ext_c), .air_ack(air_ack), .air_miss(air_miss),
      .mob_valid(mob_v), .mob_src(mob_s), .mob_dst(mob_d), .feeder_tx_busy(feed),
      .rssi_valid(rssi_v), .rssi_dbm(rssi), .prog_restart_r(prog_restart_r),
      .init_busy_r(init_busy_r), .own_addr_r(own_addr_r), .chan_r(chan_r),
      .tx_attempt_r(tx_attempt_r), .tx_bch_r(tx_bch_r), .mob_accept_r(mob_accept_r),
      .mob_reject_r(mob_reject_r), .downlink_led_r(downlink_led_r),
      .bar_led_r(bar_led_r));
   fsr_host_model host (.mclk(mclk), .reset_n(reset_n), .init_busy_r(init_busy_r),
      .resp_r(resp_r), .cmd(cmd));

   always #50 mclk = ~mclk;

   // cycle count; the ceiling is far above the few hundred cycles needed
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         miscompares = miscompares + 1;
         give_verdict();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
   endfunction : lfsr

   // two lit segments, one more per 5 dB step strictly passed
   function automatic logic [7:0] bar_exp(input logic signed [7:0] v);
      int n = 2;
      for (int t = -90; t <= -65; t += 5) if (v > t) n++;
      return 8'((9'h001 << n) - 9'h001);
   endfunction : bar_exp

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : chk_bit

   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask : chk_val

   task automatic chk_resp(input fsr_resp_e code, input logic [7:0] data);
      checked++;
      if (host.rsp_last.code !== code || host.rsp_last.data !== data) begin
         miscompares++;
         $display("unexpected at %0t: answer %0d", $time, host.rsp_last.code);
      end
   endtask : chk_resp

   // waits for a new answer under a bound; dt is counted from t0
   task automatic wait_resp(input int lim);
      while (host.rsp_cnt == n0 && cyc - t0 < lim) @(negedge mclk);
      dt = cyc - t0;
   endtask : wait_resp

   task automatic do_cmd(input fsr_cmd_e c, input logic [11:0] a, input logic [7:0] g);
      n0 = host.rsp_cnt;
      host.send(c, a, g, 1'b1);
      @(negedge mclk);
      t0 = cyc;
      wait_resp(8);
   endtask : do_cmd

   task automatic wait_idle();
      @(negedge mclk);
      t0 = cyc;
      while (init_busy_r !== 1'b0 && cyc - t0 < INIT + 8) @(negedge mclk);
   endtask : wait_idle

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict

   initial begin
      own = {4'h1, rot};
      cur = chsw;
      @(posedge mclk);
      @(negedge mclk);
      chk_val(own_addr_r, 12'h100, "reset address");
      @(posedge mclk) reset_n <= 1'b1;
      wait_idle();
      chk_val(own_addr_r, own, "own address");
      chk_val(12'(host.rsp_cnt), 12'h000, "answer after power up");
      $display("test power_up done");
      // channel writes at both bounds, just outside them, then random
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         ch = (i == 0) ? 8'h01 : (i == 1) ? 8'h32 : (i == 2) ? 8'h00 : (i == 3) ? 8'h33
            : 8'(rnd[7:0] % 50 + 1);
         ok = (ch >= 8'h01 && ch <= 8'h32);
         do_cmd(CMD_FRQ_WR, own, ch);
         chk_val(12'(dt), 12'h001, "write latency");
         chk_resp(ok ? RSP_OK : RSP_NG, 8'h00);
         if (ok) cur = ch;
         do_cmd(CMD_FRQ_RD, own, 8'h00);
         chk_resp(RSP_CHAN, cur);
         chk_val({4'h0, chan_r}, {4'h0, cur}, "channel word");
      end
      do_cmd(CMD_FRQ_RD, own ^ 12'h001, 8'h00);
      chk_val(12'(host.rsp_cnt - n0), 12'h000, "other station answered");
      $display("test channel done");
      // software reset with an impolite command thrown in during init
      n0 = host.rsp_cnt;
      host.send(CMD_RST, own, 8'h00, 1'b1);
      @(negedge mclk);
      t0 = cyc;
      chk_bit(prog_restart_r, 1'b1, "restart pulse");
      chk_bit(init_busy_r, 1'b1, "init busy");
      host.send(CMD_FRQ_WR, own, 8'h05, 1'b0);
      wait_resp(INIT + 8);
      chk_val(12'(dt), 12'(INIT + 1), "reset answer time");
      chk_resp(RSP_OK, 8'h00);
      chk_bit(init_busy_r, 1'b0, "busy after answer");
      do_cmd(CMD_FRQ_RD, own, 8'h00);
      chk_resp(RSP_CHAN, chsw);
      chk_val({4'h0, chan_r}, {4'h0, chsw}, "channel word after reset");
      $display("test soft_reset done");
      // air attempts: all missed, first acked, then random
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         miss = (k == 0) ? 6 : (k == 1) ? 0 : int'(rnd[2:0] % 7);
         n0 = host.rsp_cnt;
         host.send(CMD_TX, own, 8'h00, 1'b1);
         for (int a = 1; a <= ((miss >= 6) ? 6 : miss + 1); a++) begin
            t0 = cyc;
            while (tx_attempt_r !== 1'b1 && cyc - t0 < 4) @(negedge mclk);
            chk_bit(tx_attempt_r, 1'b1, "attempt");
            chk_bit(tx_bch_r, 1'(a >= 4), "coded attempt");
            // a second send while attempts are still open must be refused
            if (k == 0 && a == 1) begin
               do_cmd(CMD_TX, own, 8'h00);
               chk_resp(RSP_NG, 8'h00);
               n0 = host.rsp_cnt;
            end
            @(posedge mclk);
            if (a <= miss) air_miss <= 1'b1;
            else air_ack <= 1'b1;
            @(posedge mclk);
            air_miss <= 1'b0;
            air_ack <= 1'b0;
         end
         @(negedge mclk);
         t0 = cyc;
         wait_resp(8);
         chk_resp((miss >= 6) ? RSP_NG : RSP_OK, 8'h00);
      end
      $display("test air done");
      // mobile frames: range corners and random sources, both destinations
      for (int i = 0; i < 20; i++) begin
         rnd = lfsr(rnd);
         @(posedge mclk);
         mob_v <= 1'b1;
         mob_s <= (i < 12) ? srcs[i % 6] : rnd[11:0];
         mob_d <= ((i / 6) % 2 == 1) ? 12'h100 : 12'h001;
         @(posedge mclk);
         mob_v <= 1'b0;
         ok = (mob_d == 12'h001 && mob_s >= 12'h400 && mob_s <= 12'h9FF);
         @(negedge mclk);
         chk_bit(mob_accept_r, ok, "accept");
         chk_bit(mob_reject_r, !ok, "reject");
      end
      $display("test mobile done");
      // downlink indicator and level bar
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         @(posedge mclk);
         feed <= rnd[9];
         rssi_v <= 1'b1;
         rssi <= (i < 8) ? bars[i] : rnd[7:0];
         @(posedge mclk);
         rssi_v <= 1'b0;
         @(negedge mclk);
         chk_bit(downlink_led_r, feed, "downlink");
         chk_val({4'h0, bar_led_r}, {4'h0, bar_exp(rssi)}, "bar");
      end
      $display("test indicators done");
      // contact closure one cycle short of the limit, then exactly at it
      for (int k = EXT - 1; k <= EXT; k++) begin
         n0 = host.rsp_cnt;
         seen = 1'b0;
         @(posedge mclk) ext_c <= 1'b1;
         repeat (k) @(posedge mclk);
         ext_c <= 1'b0;
         repeat (6) begin
            @(negedge mclk);
            seen = seen | prog_restart_r;
         end
         chk_bit(seen, 1'(k >= EXT), "contact reset");
         wait_idle();
         chk_val(12'(host.rsp_cnt - n0), 12'h000, "answer after contact");
      end
      $display("test contact done");
      give_verdict();
   end
endmodule : fsr_top_tb
